// >>> slave_parameter_port.sv
// slave parameter port: register front end, configuration load, line sampling
// assumes a register master with one-cycle strobes and inputs synchronous to i_mclk
`timescale 1ns/100ps
`include "spp_params.svh"
module slave_parameter_port (
    input  wire logic                     i_mclk,
    input  wire logic                     i_reset,
    input  wire logic [`SPP_ADDR_W-1:0]   i_addr,
    input  wire logic [`SPP_DATA_W-1:0]   i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [`SPP_DATA_W-1:0]   o_rdata,
    input  wire logic                     i_nvm_valid,
    input  wire logic [`SPP_CFG_W-1:0]    i_nvm_cfg,
    input  wire logic [3:0]               i_param_line_in,
    output logic      [3:0]               o_param_line_out,
    output logic      [3:0]               o_param_line_oe,
    output logic                          o_parameter_strobe_out,
    output logic                          o_parameter_strobe_oe,
    output logic                          o_watchdog_enable,
    output logic                          o_filter_enable,
    output logic                          o_sync_io_enable,
    output logic                          o_data_port_enable,
    output logic                          o_data_exchange_disable
);
    spp_seq_if seq_bus ();

    spp_pkg::spp_init_state_e init_reg;
    logic [`SPP_CFG_W-1:0]    cfg_reg;
    logic [3:0]               out_reg;
    logic [3:0]               in_reg;
    logic [3:0]               ctl_reg;
    logic                     start_reg;
    logic                     dxd_reg;
    logic                     dpe_reg;
    logic                     wd_en_reg;
    logic                     filt_en_reg;
    logic                     sync_en_reg;
    logic [`SPP_DATA_W-1:0]   rdata_reg;
    logic                     pin_low_reg;

    logic wr_param;
    logic wr_clear;
    logic wr_cfg;
    logic load_evt;

    spp_port_seq #(
        .SETUP_CYC (`SPP_SETUP_CYC),
        .PST_CYC   (`SPP_PST_CYC),
        .LATCH_CYC (`SPP_LATCH_CYC)
    ) u_seq (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .bus     (seq_bus)
    );

    assign seq_bus.start = start_reg;
    assign seq_bus.value = out_reg;
    assign seq_bus.mux   = cfg_reg[`SPP_CFG_MUX];

    // parameter writes are ignored until the configuration has been loaded
    assign load_evt = (init_reg == spp_pkg::SPP_INIT_LOAD) && i_nvm_valid;
    assign wr_param = i_wr && (i_addr == `SPP_ADDR_PARAM_OUT) && (init_reg == spp_pkg::SPP_INIT_RUN);
    assign wr_clear = i_wr && (i_addr == `SPP_ADDR_CTRL) && i_wdata[`SPP_CTRL_ADDR_CLEAR]
                      && (init_reg == spp_pkg::SPP_INIT_RUN);
    assign wr_cfg   = i_wr && (i_addr == `SPP_ADDR_CFG);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            init_reg <= spp_pkg::SPP_INIT_LOAD;
        end else if (load_evt) begin
            init_reg <= spp_pkg::SPP_INIT_RUN;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cfg_reg <= `SPP_CFG_RESET;
        end else if (load_evt) begin
            cfg_reg <= i_nvm_cfg;
        end else if (wr_cfg) begin
            cfg_reg <= i_wdata[`SPP_CFG_W-1:0];
        end
    end

    // the default strobe after reset waits for the configuration load
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            out_reg <= `SPP_PARAM_RESET;
        end else if (load_evt || wr_clear) begin
            out_reg <= `SPP_PARAM_RESET;
        end else if (wr_param) begin
            out_reg <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= load_evt || wr_clear || wr_param;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            dxd_reg <= 1'b1;
        end else if (wr_clear) begin
            dxd_reg <= 1'b1;
        end else if (wr_param) begin
            dxd_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            dpe_reg <= 1'b0;
        end else if (wr_param) begin
            dpe_reg <= 1'b1;
        end
    end

    // in normal mode the sampled value applies the wired-AND explicitly so it does not
    // depend on how the external pull-up network resolves the line
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            in_reg <= `SPP_PARAM_RESET;
        end else if (seq_bus.sample) begin
            if (cfg_reg[`SPP_CFG_MUX]) begin
                in_reg <= i_param_line_in;
            end else begin
                in_reg <= out_reg & i_param_line_in;
            end
        end
    end

    // control lines always use the wired-AND, even in multiplex mode
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ctl_reg <= `SPP_PARAM_RESET;
        end else if (seq_bus.sample) begin
            ctl_reg <= out_reg & i_param_line_in;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wd_en_reg <= 1'b0;
        end else if (cfg_reg[`SPP_CFG_WD_ACTIVE]) begin
            wd_en_reg <= 1'b1;
        end else if (cfg_reg[`SPP_CFG_WD_PIN_SEL]) begin
            wd_en_reg <= ctl_reg[0];
        end else begin
            wd_en_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            filt_en_reg <= 1'b0;
        end else begin
            filt_en_reg <= cfg_reg[`SPP_CFG_FILT_PIN_SEL] && !ctl_reg[1];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            sync_en_reg <= 1'b0;
        end else begin
            sync_en_reg <= cfg_reg[`SPP_CFG_SYNC_PIN_SEL] && !ctl_reg[2];
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pin_low_reg <= 1'b0;
        end else begin
            pin_low_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdata_reg <= '0;
        end else if (i_rd) begin
            case (i_addr)
                `SPP_ADDR_PARAM_OUT: rdata_reg <= {4'h0, out_reg};
                `SPP_ADDR_PARAM_IN:  rdata_reg <= {4'h0, in_reg};
                `SPP_ADDR_CFG:       rdata_reg <= {3'h0, cfg_reg};
                `SPP_ADDR_STATUS: begin
                    rdata_reg <= {4'h0, (init_reg == spp_pkg::SPP_INIT_RUN),
                                  seq_bus.busy, dpe_reg, dxd_reg};
                end
                default:             rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign o_rdata                 = rdata_reg;
    assign o_param_line_out        = {4{pin_low_reg}};
    assign o_param_line_oe         = seq_bus.line_oe;
    assign o_parameter_strobe_out  = pin_low_reg;
    assign o_parameter_strobe_oe   = seq_bus.strobe;
    assign o_watchdog_enable       = wd_en_reg;
    assign o_filter_enable         = filt_en_reg;
    assign o_sync_io_enable        = sync_en_reg;
    assign o_data_port_enable      = dpe_reg;
    assign o_data_exchange_disable = dxd_reg;

    chk_param_write_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_param |=> out_reg == $past(i_wdata[3:0]) ##1 o_param_line_oe == ~out_reg)
        else $error("written parameter not driven on the lines");
    chk_clear_defaults: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_clear |=> out_reg == 4'hF && dxd_reg && start_reg ##1 o_param_line_oe == 4'h0)
        else $error("address clear did not restore defaults");
    chk_sample_wired_and: assert property (@(posedge i_mclk) disable iff (i_reset)
        seq_bus.sample && !cfg_reg[`SPP_CFG_MUX] |=> in_reg == $past(out_reg & i_param_line_in))
        else $error("sampled value is not the wired-AND");
    chk_ctl_wired_and: assert property (@(posedge i_mclk) disable iff (i_reset)
        seq_bus.sample |=> ctl_reg == $past(out_reg & i_param_line_in))
        else $error("control lines not the wired-AND");
    chk_first_write_enable: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_param |=> dpe_reg && !dxd_reg)
        else $error("parameter write did not enable data port");
    chk_watchdog_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
        !cfg_reg[`SPP_CFG_WD_ACTIVE] && cfg_reg[`SPP_CFG_WD_PIN_SEL] && $stable(cfg_reg)
        |=> wd_en_reg == $past(ctl_reg[0]))
        else $error("watchdog enable does not follow line 0");
    chk_filter_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
        ##1 filt_en_reg == ($past(cfg_reg[`SPP_CFG_FILT_PIN_SEL]) && !$past(ctl_reg[1])))
        else $error("filter enable does not follow line 1");
    chk_config_first: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_parameter_strobe_oe |-> init_reg == spp_pkg::SPP_INIT_RUN)
        else $error("strobe issued before configuration load");
endmodule // slave_parameter_port

// >>> spp_params.svh
// constants for the slave parameter port: offsets, fields, reset values, timing
// assumes a 10 MHz i_mclk; all timing counts below are derived from that period
// Notes on behaviour
// - latch received parameter, drive open-drain lines
// - parameter strobe pulse lasts 5 to 6 us
// - sample line inputs 11 to 13.5 us later
// - normal mode: sample is output AND external
// - multiplex mode: release drivers before sampling
// - data valid 0.1 to 0.6 us before strobe
// - multiplex mode: drivers off after strobe edge
// - reset/address clear: all ones, strobe issued
// - first parameter output enables data port
// - line 0 gates watchdog when selected
// - line 1 low activates input filters
// - line 2 low activates synchronous I/O
// - control lines use output AND external value
// - exchange disable set on clear, cleared on write
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

`define SPP_ADDR_W            5
`define SPP_DATA_W            8
`define SPP_ADDR_PARAM_OUT    5'h00
`define SPP_ADDR_PARAM_IN     5'h04
`define SPP_ADDR_CFG          5'h08
`define SPP_ADDR_STATUS       5'h0C
`define SPP_ADDR_CTRL         5'h10

`define SPP_CFG_W             5
`define SPP_CFG_MUX           0
`define SPP_CFG_WD_ACTIVE     1
`define SPP_CFG_WD_PIN_SEL    2
`define SPP_CFG_FILT_PIN_SEL  3
`define SPP_CFG_SYNC_PIN_SEL  4
`define SPP_CFG_RESET         5'h00

`define SPP_ST_DXD            0
`define SPP_ST_DPE            1
`define SPP_ST_BUSY           2
`define SPP_ST_INIT_DONE      3
`define SPP_CTRL_ADDR_CLEAR   0

`define SPP_PARAM_RESET       4'hF

`define SPP_CLK_NS            100
`define SPP_T_SETUP_NS        500
`define SPP_T_PST_MIN_NS      5000
`define SPP_T_PST_MAX_NS      6000
`define SPP_T_LATCH_MIN_NS    11000
`define SPP_T_LATCH_MAX_NS    13500
`define SPP_SETUP_CYC         (`SPP_T_SETUP_NS / `SPP_CLK_NS)
`define SPP_PST_CYC           ((`SPP_T_PST_MIN_NS + `SPP_CLK_NS - 1) / `SPP_CLK_NS)
`define SPP_LATCH_MIN_CYC     ((`SPP_T_LATCH_MIN_NS + `SPP_CLK_NS - 1) / `SPP_CLK_NS)
`define SPP_LATCH_MAX_CYC     (`SPP_T_LATCH_MAX_NS / `SPP_CLK_NS)
`define SPP_LATCH_CYC         ((`SPP_LATCH_MIN_CYC + `SPP_LATCH_MAX_CYC) / 2)

`endif

// >>> spp_pkg.sv
// types shared by the parameter port modules
// assumes nothing beyond a SystemVerilog compiler
package spp_pkg;

    typedef enum logic [1:0] {
        SPP_SEQ_IDLE   = 2'b00,
        SPP_SEQ_SETUP  = 2'b01,
        SPP_SEQ_STROBE = 2'b10,
        SPP_SEQ_WAIT   = 2'b11
    } spp_seq_state_e;

    typedef enum logic {
        SPP_INIT_LOAD = 1'b0,
        SPP_INIT_RUN  = 1'b1
    } spp_init_state_e;

endpackage

// >>> spp_seq_if.sv
// carrier between the port controller and the output timing sequencer
// assumes both ends share i_mclk
`timescale 1ns/100ps
interface spp_seq_if;
    logic       start;
    logic [3:0] value;
    logic       mux;
    logic [3:0] line_oe;
    logic       strobe;
    logic       sample;
    logic       busy;

    modport ctrl (output start, value, mux, input line_oe, strobe, sample, busy);
    modport seq  (input start, value, mux, output line_oe, strobe, sample, busy);
endinterface

// >>> spp_port_seq.sv
// output timing sequencer: places data, strobes, releases in multiplex mode, marks the sample point
// assumes start is a one-cycle pulse; a new start restarts the sequence
`timescale 1ns/100ps
`include "spp_params.svh"
module spp_port_seq #(
    parameter int SETUP_CYC = `SPP_SETUP_CYC,
    parameter int PST_CYC   = `SPP_PST_CYC,
    parameter int LATCH_CYC = `SPP_LATCH_CYC
) (
    input  wire logic i_mclk,
    input  wire logic i_reset,
    spp_seq_if.seq    bus
);
    localparam logic [7:0] SETUP_END = 8'(SETUP_CYC - 1);
    localparam logic [7:0] PST_END   = 8'(SETUP_CYC + PST_CYC - 1);
    localparam logic [7:0] LATCH_END = 8'(LATCH_CYC - 1);

    spp_pkg::spp_seq_state_e state_reg;
    logic [7:0]              cnt_reg;
    logic [3:0]              oe_reg;
    logic                    strobe_reg;
    logic                    sample_reg;

    assign bus.line_oe = oe_reg;
    assign bus.strobe  = strobe_reg;
    assign bus.sample  = sample_reg;
    assign bus.busy    = (state_reg != spp_pkg::SPP_SEQ_IDLE);

    always_ff @(posedge i_mclk) begin
        if (i_reset || bus.start) begin
            cnt_reg <= 8'h00;
        end else if (state_reg != spp_pkg::SPP_SEQ_IDLE) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state_reg <= spp_pkg::SPP_SEQ_IDLE;
        end else if (bus.start) begin
            state_reg <= spp_pkg::SPP_SEQ_SETUP;
        end else begin
            case (state_reg)
                spp_pkg::SPP_SEQ_SETUP: begin
                    if (cnt_reg == SETUP_END) state_reg <= spp_pkg::SPP_SEQ_STROBE;
                end
                spp_pkg::SPP_SEQ_STROBE: begin
                    if (cnt_reg == PST_END) state_reg <= spp_pkg::SPP_SEQ_WAIT;
                end
                spp_pkg::SPP_SEQ_WAIT: begin
                    if (cnt_reg == LATCH_END) state_reg <= spp_pkg::SPP_SEQ_IDLE;
                end
                default: state_reg <= spp_pkg::SPP_SEQ_IDLE;
            endcase
        end
    end

    // open drain: a line is pulled only where the value bit is zero
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            oe_reg <= 4'h0;
        end else if (bus.start) begin
            oe_reg <= ~bus.value;
        end else if (state_reg == spp_pkg::SPP_SEQ_STROBE && cnt_reg == PST_END && bus.mux) begin
            oe_reg <= 4'h0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset || bus.start) begin
            strobe_reg <= 1'b0;
        end else if (state_reg == spp_pkg::SPP_SEQ_SETUP && cnt_reg == SETUP_END) begin
            strobe_reg <= 1'b1;
        end else if (state_reg == spp_pkg::SPP_SEQ_STROBE && cnt_reg == PST_END) begin
            strobe_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset || bus.start) begin
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= (state_reg == spp_pkg::SPP_SEQ_WAIT) && (cnt_reg == LATCH_END);
        end
    end

    chk_strobe_setup_time: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(strobe_reg) |-> cnt_reg == SETUP_END + 8'h01)
        else $error("strobe did not follow data by the setup time");
    chk_strobe_pulse_width: assert property (@(posedge i_mclk) disable iff (i_reset)
        $fell(strobe_reg) && !$past(bus.start) |-> cnt_reg == PST_END + 8'h01)
        else $error("strobe pulse width wrong");
    chk_sample_point_time: assert property (@(posedge i_mclk) disable iff (i_reset)
        sample_reg |-> cnt_reg == LATCH_END + 8'h01 && !strobe_reg)
        else $error("sample point outside acceptance window");
    chk_mux_driver_release: assert property (@(posedge i_mclk) disable iff (i_reset)
        $fell(strobe_reg) && !$past(bus.start) && $past(bus.mux) |-> oe_reg == 4'h0)
        else $error("drivers not released after strobe in multiplex mode");
endmodule // spp_port_seq

// >>> spp_ext_logic.sv
// external controller model sitting on the open-drain parameter lines
// assumes the bench forms the wire level with a pull-up; o_pull high means line pulled low
`timescale 1ns/100ps
module spp_ext_logic (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_strobe_oe,
    input  wire logic [3:0] i_line,
    input  wire logic [3:0] i_ret,
    input  wire logic [7:0] i_delay,
    output logic      [3:0] o_pull,
    output logic      [3:0] o_seen
);
    logic       strobe_d_reg;
    logic       run_reg;
    logic [7:0] cnt_reg;

    // i_delay sets a prompt or slow answer; the hold ends at the close of the sample window
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            strobe_d_reg <= 1'b0;
            run_reg      <= 1'b0;
            cnt_reg      <= 8'h00;
            o_pull       <= 4'h0;
            o_seen       <= 4'h0;
        end else begin
            strobe_d_reg <= i_strobe_oe;
            if (i_strobe_oe) begin
                o_seen  <= i_line;
                o_pull  <= 4'h0;
                run_reg <= 1'b0;
            end else if (strobe_d_reg) begin
                run_reg <= 1'b1;
                cnt_reg <= 8'h00;
            end else if (run_reg) begin
                cnt_reg <= cnt_reg + 8'h01;
                if (cnt_reg == i_delay) begin
                    o_pull <= ~i_ret;
                end
                if (cnt_reg == 8'h50) begin
                    o_pull  <= 4'h0;
                    run_reg <= 1'b0;
                end
            end
        end
    end
endmodule // spp_ext_logic

// >>> tb_top.sv
// self-checking bench: register master, external logic model, timing and value checks
// assumes the design files and spp_ext_logic.sv are compiled before this one
`timescale 1ns/100ps
`include "spp_params.svh"
module tb_top;
    logic                   i_mclk;
    logic                   i_reset;
    logic [`SPP_ADDR_W-1:0] i_addr;
    logic [`SPP_DATA_W-1:0] i_wdata;
    logic                   i_wr;
    logic                   i_rd;
    logic [`SPP_DATA_W-1:0] o_rdata;
    logic                   i_nvm_valid;
    logic [`SPP_CFG_W-1:0]  i_nvm_cfg;
    logic [3:0]             line;
    logic [3:0]             o_param_line_out;
    logic [3:0]             o_param_line_oe;
    logic                   o_parameter_strobe_out;
    logic                   o_parameter_strobe_oe;
    logic                   o_watchdog_enable;
    logic                   o_filter_enable;
    logic                   o_sync_io_enable;
    logic                   o_data_port_enable;
    logic                   o_data_exchange_disable;
    logic [3:0]             ext_pull;
    logic [3:0]             ext_seen;
    logic [3:0]             ret;
    logic [7:0]             dly;
    logic [4:0]             cfg;
    logic [7:0]             rv;
    int                     n_errors;
    int                     cmp_count;

    // pull-up wire: any party pulling wins
    assign line = ~(o_param_line_oe | ext_pull);

    slave_parameter_port i_slave_parameter_port (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_nvm_valid(i_nvm_valid),
        .i_nvm_cfg(i_nvm_cfg), .i_param_line_in(line), .o_param_line_out(o_param_line_out),
        .o_param_line_oe(o_param_line_oe), .o_parameter_strobe_out(o_parameter_strobe_out),
        .o_parameter_strobe_oe(o_parameter_strobe_oe), .o_watchdog_enable(o_watchdog_enable),
        .o_filter_enable(o_filter_enable), .o_sync_io_enable(o_sync_io_enable),
        .o_data_port_enable(o_data_port_enable),
        .o_data_exchange_disable(o_data_exchange_disable)
    );

    spp_ext_logic i_spp_ext_logic (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_strobe_oe(o_parameter_strobe_oe),
        .i_line(line), .i_ret(ret), .i_delay(dly), .o_pull(ext_pull), .o_seen(ext_seen)
    );

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            n_errors++;
            $display("[ERR] t=%0t cycles got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    // counts edges from the first edge after the call; a strobe still high from an aborted run is not a rise
    task automatic watch(input logic [3:0] v, input logic mux, input bit timed);
        int         k_rise;
        int         k_fall;
        logic       prev;
        logic [3:0] oe_pre;
        logic [3:0] oe_post;
        k_rise = 0;
        k_fall = 0;
        prev = 1'b1;
        oe_pre = 4'h0;
        oe_post = 4'h0;
        for (int k = 1; k <= 127; k++) begin
            @(posedge i_mclk);
            #1;
            if (o_parameter_strobe_oe === 1'b1 && prev === 1'b0 && k_rise == 0) begin
                k_rise = k;
                oe_pre = o_param_line_oe;
            end
            if (o_parameter_strobe_oe === 1'b0 && k_rise != 0 && k_fall == 0) begin
                k_fall = k;
                oe_post = o_param_line_oe;
            end
            prev = o_parameter_strobe_oe;
        end
        // timed calls follow a taken write, so k = 1 is the edge that takes the start pulse
        if (timed) begin
            chk_cyc(k_rise, `SPP_SETUP_CYC + 1);
            chk_cyc(k_fall, `SPP_SETUP_CYC + `SPP_PST_CYC + 1);
        end
        chk_cyc(k_fall - k_rise, `SPP_PST_CYC);
        // cast keeps the inversion at four bits inside the wider argument
        chk_val(oe_pre, 4'(~v));
        chk_val(oe_post, mux ? 4'h0 : 4'(~v));
        chk_val(o_param_line_oe, mux ? 4'h0 : 4'(~v));
    endtask

    task automatic init_dut(input logic [4:0] nv);
        @(posedge i_mclk);
        i_reset     <= 1'b1;
        i_nvm_valid <= 1'b0;
        i_nvm_cfg   <= nv;
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1;
        chk_val({o_param_line_out, o_parameter_strobe_out, o_param_line_oe,
                 o_parameter_strobe_oe, o_data_port_enable,
                 o_data_exchange_disable}, 32'h01);
        @(posedge i_mclk);
        i_nvm_valid <= 1'b1;
        watch(4'hF, 1'b0, 1'b0);
        rd(`SPP_ADDR_CFG, rv);
        chk_val(rv, {3'h0, nv});
        chk_val(o_data_port_enable, 1'b0);
        cfg = nv;
        $display("test init done");
    endtask

    task automatic param_test(input logic [3:0] v);
        logic [3:0] exp_in;
        logic [3:0] exp_ctl;
        @(posedge i_mclk);
        ret <= 4'($urandom);
        dly <= 8'($urandom_range(12, 0));
        wr(`SPP_ADDR_PARAM_OUT, {4'h0, v});
        watch(v, cfg[0], 1'b1);
        exp_in = cfg[0] ? ret : (v & ret);
        // control lines keep the wired-AND even when the port is multiplexed
        exp_ctl = v & ret;
        rd(`SPP_ADDR_PARAM_IN, rv);
        chk_val(rv, {4'h0, exp_in});
        chk_val(ext_seen, v);
        chk_val(o_watchdog_enable, cfg[1] | (cfg[2] & exp_ctl[0]));
        chk_val(o_filter_enable, cfg[3] & ~exp_ctl[1]);
        chk_val(o_sync_io_enable, cfg[4] & ~exp_ctl[2]);
        rd(`SPP_ADDR_STATUS, rv);
        chk_val(rv, 8'h0A);
        $display("test param %h cfg %h done", v, cfg);
    endtask

    initial begin
        repeat (20000) @(posedge i_mclk);
        n_errors++;
        test_done;
    end

    initial begin
        i_reset     = 1'b1;
        i_addr      = 5'h00;
        i_wdata     = 8'h00;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        i_nvm_valid = 1'b0;
        i_nvm_cfg   = 5'h00;
        ret         = 4'hF;
        dly         = 8'h00;
        n_errors    = 0;
        cmp_count   = 0;
        void'($urandom(32'h8215771b));
        init_dut(5'($urandom));
        rd(5'h1C, rv);
        chk_val(rv, 8'h00);
        for (int i = 0; i < 8; i++) begin
            cfg = 5'($urandom);
            // even passes keep the compatible wired-AND mode
            cfg[0] = i[0];
            wr(`SPP_ADDR_CFG, {3'h0, cfg});
            param_test(i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'($urandom));
        end
        wr(`SPP_ADDR_CTRL, 8'h01);
        watch(4'hF, cfg[0], 1'b1);
        rd(`SPP_ADDR_STATUS, rv);
        chk_val(rv, 8'h0B);
        $display("test address clear done");
        wr(`SPP_ADDR_PARAM_OUT, 8'h03);
        repeat (20) @(posedge i_mclk);
        wr(`SPP_ADDR_PARAM_OUT, 8'h0C);
        watch(4'hC, cfg[0], 1'b1);
        $display("test restart done");
        init_dut(5'($urandom));
        test_done;
    end
endmodule // tb_top
